// *** pkg/cff_cfg.svh ***
`ifndef CFF_CFG_SVH
`define CFF_CFG_SVH

////////////////////////////////////////////////////////////////////////
// Geometry
`define CFF_TAPS 32
`define CFF_COEF_W 16
`define CFF_ACC_W 36
`define CFF_OUT_W 24
`define CFF_ADDR_W 6
`define CFF_DATA_W 16

////////////////////////////////////////////////////////////////////////
// Register offsets (words); coefficients occupy 6'h00 to 6'h1F
`define CFF_A_CTRL 6'h20
`define CFF_A_DIR 6'h21
`define CFF_A_DOH 6'h22
`define CFF_A_DOL 6'h23
`define CFF_A_STAT 6'h24

////////////////////////////////////////////////////////////////////////
// Control fields and reset values
`define CFF_CTRL_CW 1:0
`define CFF_CTRL_SEL 3:2
`define CFF_CTRL_MASTER 4
`define CFF_CTRL_PORT 5
`define CFF_CTRL_RST 16'h0013
`define CFF_STAT_BUSY 0
`define CFF_STAT_READY 1
`define CFF_STAT_OVR 2

////////////////////////////////////////////////////////////////////////
// Selector start bits for codes 0 to 3
`define CFF_SEL0 5'd7
`define CFF_SEL1 5'd11
`define CFF_SEL2 5'd15
`define CFF_SEL3 5'd20
`endif

// *** pkg/cff_pkg.sv ***
`include "cff_cfg.svh"
package cff_pkg;
    typedef logic [`CFF_ADDR_W-1:0] cff_addr_t;
    typedef logic [`CFF_DATA_W-1:0] cff_data_t;
    typedef logic [`CFF_OUT_W-1:0] cff_out_t;
    typedef logic signed [`CFF_ACC_W-1:0] cff_acc_t;

    typedef enum logic [1:0] {PH_IDLE, PH_MAC, PH_ADD, PH_PUSH} cff_phase_e;
    typedef enum logic [1:0] {HS_IDLE, HS_BUS, HS_WAIT} cff_hphase_e;

    // Device state
    typedef struct packed {
        logic [`CFF_TAPS-1:0][`CFF_COEF_W-1:0] coef;
        logic [`CFF_TAPS-1:0][`CFF_DATA_W-1:0] dline;
        cff_data_t ctrl;
        cff_data_t smp;
        cff_acc_t acc;
        cff_acc_t cas_out;
        logic [4:0] tap;
        cff_phase_e phase;
        cff_out_t result;
        cff_out_t held;
        logic ready;
        logic overrun;
        logic go_out;
        logic busy;
        cff_data_t rdata;
    } cff_dev_s;

    // Host state
    typedef struct packed {
        cff_hphase_e phase;
        cff_addr_t addr;
        cff_data_t wdata;
        logic rw;
        logic sel_b;
        logic cmd_ready;
        logic rsp_valid;
        cff_data_t rsp_data;
        cff_data_t din;
        logic din_valid;
        logic res_valid;
        cff_out_t res_data;
        logic dout_ready;
    } cff_host_s;
endpackage : cff_pkg

// *** pkg/cff_if.sv ***
`timescale 1ns/100ps
interface cff_if;
    import cff_pkg::*;
    cff_addr_t addr;
    cff_data_t wdata;
    cff_data_t rdata;
    logic rw;
    logic ce_b;
    logic cs_b;
    cff_data_t din;
    logic din_valid;
    cff_out_t dout;
    logic dout_valid;
    logic dout_ready;
    cff_acc_t cas_in;
    cff_acc_t cas_out;
    logic go_in;
    logic go_out;

    modport dev (
        input addr, wdata, rw, ce_b, cs_b, din, din_valid, dout_ready, cas_in, go_in,
        output rdata, dout, dout_valid, cas_out, go_out
    );
    modport host (
        output addr, wdata, rw, ce_b, cs_b, din, din_valid, dout_ready, cas_in, go_in,
        input rdata, dout, dout_valid, cas_out, go_out
    );
endinterface : cff_if

// *** verilog/cff_buf.sv ***
`timescale 1ns/100ps
module cff_buf #(
    parameter int W = 24
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import cff_pkg::*;
    typedef struct packed {
        logic [1:0][W-1:0] slot;
        logic [1:0] cnt;
    } cff_buf_s;
    cff_buf_s st, next_st;
    logic push, pop;
    logic [1:0] n;

    ////////////////////////////////////////////////////////////////////
    // Handshakes straight off the state so both sides see honest flags
    assign in_ready = (st.cnt != 2'd2);
    assign out_valid = (st.cnt != 2'd0);
    assign out_data = st.slot[0];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pop shifts the tail forward; push lands behind what remains
    always_comb begin
        next_st = st;
        n = st.cnt - {1'b0, pop};
        if (pop) begin
            next_st.slot[0] = st.slot[1];
        end
        if (push) begin
            next_st.slot[n[0]] = in_data;
        end
        next_st.cnt = n + {1'b0, push};
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : cff_buf

// *** verilog/cff_dev.sv ***
`timescale 1ns/100ps
module cff_dev (
    input wire logic mclk,
    input wire logic rst_b,
    cff_if.dev link,
    output logic busy
);
    import cff_pkg::*;

    cff_dev_s st, next_st;
    logic take, wr, rd, trigger, start;
    cff_data_t sample;
    logic buf_in_ready, buf_out_valid, buf_out_ready;
    cff_out_t buf_data;
    logic signed [31:0] prod;
    cff_acc_t sum;
    cff_out_t sel_word;

    ////////////////////////////////////////////////////////////////////
    // Coefficient sign extension by programmed word width
    function automatic logic signed [15:0] coef_ext(input logic [15:0] c, input logic [1:0] cw);
        logic signed [15:0] r;
        r = $signed(c);
        unique case (cw)
            2'd0: r = $signed({{12{c[3]}}, c[3:0]});
            2'd1: r = $signed({{8{c[7]}}, c[7:0]});
            2'd2: r = $signed({{4{c[11]}}, c[11:0]});
            2'd3: r = $signed(c);
        endcase
        return r;
    endfunction : coef_ext

    // Round at the bit below the start, then take 24 bits sign-extended
    function automatic cff_out_t select_word(input cff_acc_t v, input logic [1:0] sel);
        logic [4:0] sh;
        logic signed [36:0] w;
        sh = `CFF_SEL0;
        unique case (sel)
            2'd0: sh = `CFF_SEL0;
            2'd1: sh = `CFF_SEL1;
            2'd2: sh = `CFF_SEL2;
            2'd3: sh = `CFF_SEL3;
        endcase
        w = {v[`CFF_ACC_W-1], v} + (37'sd1 <<< (sh - 5'd1));
        w = w >>> sh;
        return w[`CFF_OUT_W-1:0];
    endfunction : select_word

    ////////////////////////////////////////////////////////////////////
    // Bus decode; access taken on each rising mclk edge with both selects low
    assign take = !link.cs_b && !link.ce_b;
    assign wr = take && !link.rw;
    assign rd = take && link.rw;

    // Sample source follows port mode
    assign trigger = st.ctrl[`CFF_CTRL_PORT] ? link.din_valid : (wr && link.addr == `CFF_A_DIR);
    assign sample = st.ctrl[`CFF_CTRL_PORT] ? link.din : link.wdata;

    // Master starts from its own registered pulse so every device starts together
    assign start = st.ctrl[`CFF_CTRL_MASTER] ? st.go_out : link.go_in;

    ////////////////////////////////////////////////////////////////////
    // Datapath terms
    assign prod = coef_ext(st.coef[st.tap], st.ctrl[`CFF_CTRL_CW]) * $signed(st.dline[st.tap]);
    assign sum = st.acc + link.cas_in;
    assign sel_word = select_word(sum, st.ctrl[`CFF_CTRL_SEL]);

    // Drain: port mode to the far end, bus mode into the held result
    assign buf_out_ready = st.ctrl[`CFF_CTRL_PORT] ? link.dout_ready : !st.ready;

    ////////////////////////////////////////////////////////////////////
    // Two-entry buffer keeps results while the receiver stalls
    cff_buf #(
        .W(`CFF_OUT_W)
    ) u_buf (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(st.phase == PH_PUSH),
        .in_ready(buf_in_ready),
        .in_data(st.result),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Next state: registers, compute sequence, result handling
    always_comb begin
        next_st = st;
        next_st.go_out = 1'b0;

        // Register writes
        if (wr) begin
            if (link.addr[5] == 1'b0) begin
                next_st.coef[link.addr[4:0]] = link.wdata;
            end else if (link.addr == `CFF_A_CTRL) begin
                next_st.ctrl = link.wdata;
            end else if (link.addr == `CFF_A_STAT) begin
                next_st.overrun = 1'b0;
            end
        end

        // Capture sample; master also issues the chain start
        if (trigger) begin
            next_st.smp = sample;
            next_st.go_out = st.ctrl[`CFF_CTRL_MASTER];
        end

        // Reading the low result word releases the holding register
        if (rd && link.addr == `CFF_A_DOL) begin
            next_st.ready = 1'b0;
        end

        // Register reads, answered one cycle later
        if (rd) begin
            next_st.rdata = '0;
            if (link.addr[5] == 1'b0) begin
                next_st.rdata = st.coef[link.addr[4:0]];
            end else begin
                unique case (link.addr)
                    `CFF_A_CTRL: next_st.rdata = st.ctrl;
                    `CFF_A_DIR: next_st.rdata = st.smp;
                    `CFF_A_DOH: next_st.rdata = {{8{st.held[23]}}, st.held[23:16]};
                    `CFF_A_DOL: next_st.rdata = st.held[15:0];
                    `CFF_A_STAT: next_st.rdata = {13'h0000, st.overrun, st.ready, st.busy};
                    default: next_st.rdata = '0;
                endcase
            end
        end

        // Sequencer: one tap per cycle, then cascade add, then push
        unique case (st.phase)
            PH_IDLE: begin
                if (start) begin
                    next_st.dline = {st.dline[`CFF_TAPS-2:0], st.smp};
                    next_st.acc = '0;
                    next_st.tap = '0;
                    next_st.phase = PH_MAC;
                end
            end
            PH_MAC: begin
                // 36 bits hold 32 full-scale products without wrap, except 32 of -32768 times -32768
                next_st.acc = st.acc + cff_acc_t'(prod);
                next_st.tap = st.tap + 5'd1;
                if (st.tap == 5'd31) begin
                    next_st.phase = PH_ADD;
                end
            end
            PH_ADD: begin
                next_st.cas_out = sum;
                next_st.result = sel_word;
                next_st.phase = PH_PUSH;
            end
            PH_PUSH: begin
                if (buf_in_ready) begin
                    next_st.phase = PH_IDLE;
                end
            end
        endcase

        // A start while still working is dropped and flagged; flag set beats clear
        if (start && st.phase != PH_IDLE) begin
            next_st.overrun = 1'b1;
        end

        // Bus mode: move buffer head into the held result; set beats clear
        if (!st.ctrl[`CFF_CTRL_PORT] && buf_out_valid && !st.ready) begin
            next_st.held = buf_data;
            next_st.ready = 1'b1;
        end

        next_st.busy = (next_st.phase != PH_IDLE);
    end

    ////////////////////////////////////////////////////////////////////
    // State register; control comes up as 16-bit words, start at bit 7, master, bus mode
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st <= '0;
            st.ctrl <= `CFF_CTRL_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign link.rdata = st.rdata;
    assign link.cas_out = st.cas_out;
    assign link.go_out = st.go_out;
    assign link.dout = buf_data;
    assign link.dout_valid = buf_out_valid;
    assign busy = st.busy;
endmodule : cff_dev

// *** verilog/cff_host.sv ***
`timescale 1ns/100ps
module cff_host (
    input wire logic mclk,
    input wire logic rst_b,
    cff_if.host link,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire cff_pkg::cff_addr_t cmd_addr,
    input wire cff_pkg::cff_data_t cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output cff_pkg::cff_data_t rsp_data,
    input wire logic smp_valid,
    input wire cff_pkg::cff_data_t smp_data,
    output logic res_valid,
    output cff_pkg::cff_out_t res_data,
    input wire logic res_ready
);
    import cff_pkg::*;
    cff_host_s st, next_st;

    ////////////////////////////////////////////////////////////////////
    // Bus cycle: accept, drive one cycle, then on a read wait for read data; a write returns to idle
    always_comb begin
        next_st = st;
        next_st.rsp_valid = 1'b0;
        next_st.din_valid = smp_valid;
        next_st.din = smp_data;
        unique case (st.phase)
            HS_IDLE: begin
                if (cmd_valid && st.cmd_ready) begin
                    next_st.addr = cmd_addr;
                    next_st.wdata = cmd_wdata;
                    next_st.rw = !cmd_write;
                    next_st.sel_b = 1'b0;
                    next_st.cmd_ready = 1'b0;
                    next_st.phase = HS_BUS;
                end
            end
            HS_BUS: begin
                next_st.sel_b = 1'b1;
                next_st.rw = 1'b1;
                if (st.rw) begin
                    next_st.phase = HS_WAIT;
                end else begin
                    next_st.cmd_ready = 1'b1;
                    next_st.phase = HS_IDLE;
                end
            end
            HS_WAIT: begin
                next_st.rsp_data = link.rdata;
                next_st.rsp_valid = 1'b1;
                next_st.cmd_ready = 1'b1;
                next_st.phase = HS_IDLE;
            end
            default: next_st.phase = HS_IDLE;
        endcase

        // Result port: one-word holding register, ready only while empty
        if (res_valid && res_ready) begin
            next_st.res_valid = 1'b0;
        end
        if (link.dout_valid && st.dout_ready) begin
            next_st.res_data = link.dout;
            next_st.res_valid = 1'b1;
        end
        next_st.dout_ready = !next_st.res_valid;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st <= '0;
            st.rw <= 1'b1;
            st.sel_b <= 1'b1;
            st.cmd_ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Head of chain: cascade grounded, device itself is master
    assign link.cas_in = '0;
    assign link.go_in = 1'b0;
    assign link.addr = st.addr;
    assign link.wdata = st.wdata;
    assign link.rw = st.rw;
    assign link.ce_b = st.sel_b;
    assign link.cs_b = st.sel_b;
    assign link.din = st.din;
    assign link.din_valid = st.din_valid;
    assign link.dout_ready = st.dout_ready;
    assign cmd_ready = st.cmd_ready;
    assign rsp_valid = st.rsp_valid;
    assign rsp_data = st.rsp_data;
    assign res_valid = st.res_valid;
    assign res_data = st.res_data;
endmodule : cff_host

// *** verification/cff_chk_sva.sv ***
`timescale 1ns/100ps
`include "cff_cfg.svh"
module cff_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire cff_pkg::cff_addr_t addr,
    input wire cff_pkg::cff_data_t wdata,
    input wire cff_pkg::cff_data_t rdata,
    input wire logic rw,
    input wire logic ce_b,
    input wire logic cs_b,
    input wire cff_pkg::cff_data_t din,
    input wire logic din_valid,
    input wire cff_pkg::cff_out_t dout,
    input wire logic dout_valid,
    input wire logic dout_ready,
    input wire cff_pkg::cff_acc_t cas_in,
    input wire cff_pkg::cff_acc_t cas_out,
    input wire logic go_in,
    input wire logic go_out
);
    import cff_pkg::*;
    logic [1:0] sel_code;
    logic port_mode;
    logic dir_wr, bus_rd, trig;
    logic [5:0] since_go;

    // Round a full sum the way the selector should
    function automatic cff_out_t rnd(input cff_acc_t a, input logic [1:0] c);
        int s;
        cff_acc_t r;
        s = (c == 2'd0) ? 7 : (c == 2'd1) ? 11 : (c == 2'd2) ? 15 : 20;
        r = (a + (cff_acc_t'(1) <<< (s - 1))) >>> s;
        return r[`CFF_OUT_W-1:0];
    endfunction : rnd

    ////////////////////////////////////////////////////////////////////////
    // Shadow of control fields; reset matches selector code 0, bus mode
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sel_code <= 2'd0;
            port_mode <= 1'b0;
        end else if (!cs_b && !ce_b && !rw && addr == `CFF_A_CTRL) begin
            sel_code <= wdata[`CFF_CTRL_SEL];
            port_mode <= wdata[`CFF_CTRL_PORT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus strobes as the device sees them, kept as plain signals for $past
    assign dir_wr = !cs_b && !ce_b && !rw && addr == `CFF_A_DIR;
    assign bus_rd = !cs_b && !ce_b && rw;
    assign trig = port_mode ? din_valid : dir_wr;

    // Cycles since the last start pulse; a start closer than this is dropped
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            since_go <= 6'h3F;
        end else if (go_out) begin
            since_go <= '0;
        end else if (since_go != 6'h3F) begin
            since_go <= since_go + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_sel_pair: assert property (ce_b == cs_b) else $error("selects differ");
    a_sel_single: assert property (!cs_b |=> cs_b) else $error("select held low");
    a_head_ground: assert property (cas_in == '0 && !go_in) else $error("chain head not grounded");
    a_go_pulse: assert property (go_out |=> !go_out) else $error("start pulse too long");
    a_go_cause: assert property (go_out |-> $past(trig))
        else $error("start without sample");
    a_result_due: assert property (go_out && since_go >= 6'd34 |-> ##35 dout_valid)
        else $error("result late");
    a_cas_update: assert property ($changed(cas_out) |-> $past(go_out, 34))
        else $error("cascade sum moved off time");
    a_round_sel: assert property ($rose(dout_valid) |-> dout == rnd(cas_out, sel_code))
        else $error("selector output wrong");
    a_rdata_hold: assert property ($changed(rdata) |-> $past(bus_rd)) else $error("read data moved");
    a_dout_stall: assert property (port_mode && dout_valid && !dout_ready |=> dout_valid && $stable(dout))
        else $error("stalled word lost");
endmodule : cff_chk

// *** verification/cascadable_fir_filter_datapath_bench.sv ***
`timescale 1ns/100ps
`include "cff_cfg.svh"
module cascadable_fir_filter_datapath_bench;
    import cff_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    cff_addr_t cmd_addr = '0;
    cff_data_t cmd_wdata = '0;
    logic cmd_ready;
    logic rsp_valid;
    cff_data_t rsp_data;
    logic smp_valid = 1'b0;
    cff_data_t smp_data = '0;
    logic res_valid;
    cff_out_t res_data;
    logic res_ready = 1'b1;
    int fails = 0;
    int compares = 0;
    cff_data_t rd_val;
    logic busy;
    int shift_tab [4] = '{7, 11, 15, 20};

    // 100 ns clock
    always #50 mclk = ~mclk;

    cff_if link ();
    cff_dev u_cff_dev (.mclk(mclk), .rst_b(rst_b), .link(link.dev), .busy(busy));
    cff_host u_cff_host (.mclk(mclk), .rst_b(rst_b), .link(link.host), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .smp_valid(smp_valid), .smp_data(smp_data),
        .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));
    cff_chk u_cff_chk (.mclk(mclk), .rst_b(rst_b), .addr(link.addr), .wdata(link.wdata),
        .rdata(link.rdata), .rw(link.rw), .ce_b(link.ce_b), .cs_b(link.cs_b), .din(link.din),
        .din_valid(link.din_valid), .dout(link.dout), .dout_valid(link.dout_valid),
        .dout_ready(link.dout_ready), .cas_in(link.cas_in), .cas_out(link.cas_out),
        .go_in(link.go_in), .go_out(link.go_out));

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input cff_out_t got, input cff_out_t exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // One command; request held until the edge that takes it
    task automatic bus(input logic wr, input cff_addr_t a, input cff_data_t d);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = d;
        while (cmd_ready !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
        while (!wr && rsp_valid !== 1'b1) @(negedge mclk);
        rd_val = rsp_data;
    endtask : bus

    task automatic rd_cmp(input cff_addr_t a, input cff_out_t exp);
        bus(1'b0, a, '0);
        cmp(cff_out_t'(rd_val), exp);
    endtask : rd_cmp

    task automatic cfg(input int cw, input int sc, input logic port);
        bus(1'b1, `CFF_A_CTRL, cff_data_t'({port, 1'b1, 2'(sc), 2'(cw)}));
    endtask : cfg

    // Tap 0 gets val; other taps zero unless all is set
    task automatic load(input cff_data_t val, input logic all);
        for (int k = 0; k < 32; k++) begin
            bus(1'b1, cff_addr_t'(k), (k == 0 || all) ? val : '0);
        end
    endtask : load

    // Host-fed sample; poll until the result is held, then read it out
    task automatic run(input cff_data_t x, input logic chk, input cff_out_t exp);
        int n;
        bus(1'b1, `CFF_A_DIR, x);
        n = 0;
        rd_val = '0;
        while (rd_val[`CFF_STAT_READY] !== 1'b1 && n < 20) begin
            bus(1'b0, `CFF_A_STAT, '0);
            // First poll lands mid-sum: busy, nothing held, no overrun
            if (n == 0) cmp(cff_out_t'(busy), 24'h00_0001);
            if (n == 0) cmp(cff_out_t'(rd_val), 24'h00_0001);
            n++;
        end
        // A poll limit that runs out counts as a mismatch
        cmp(cff_out_t'(rd_val[`CFF_STAT_READY]), 24'h00_0001);
        bus(1'b0, `CFF_A_DOH, '0);
        if (chk) cmp(cff_out_t'(rd_val), {{8{exp[23]}}, exp[23:16]});
        bus(1'b0, `CFF_A_DOL, '0);
        if (chk) cmp(cff_out_t'(rd_val), exp[15:0]);
        if (chk) rd_cmp(`CFF_A_DIR, x);
    endtask : run

    task automatic feed(input cff_data_t x);
        smp_valid = 1'b1;
        smp_data = x;
        @(negedge mclk);
        smp_valid = 1'b0;
        repeat (40) @(negedge mclk);
    endtask : feed

    task automatic take(input cff_out_t exp);
        int n;
        n = 0;
        while (res_valid !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        cmp(cff_out_t'(res_valid), 24'h00_0001);
        cmp(res_data, exp);
        @(negedge mclk);
    endtask : take

    // Expected output worked out from the arithmetic alone
    function automatic cff_out_t expect_out(input int cw, input int sc, input cff_data_t c,
        input cff_data_t x, input int taps);
        int w;
        logic signed [15:0] cs;
        longint acc;
        w = 4 * (cw + 1);
        cs = $signed(c << (16 - w)) >>> (16 - w);
        acc = longint'(taps) * longint'(cs) * longint'($signed(x));
        acc = (acc + (64'sd1 <<< (shift_tab[sc] - 1))) >>> shift_tab[sc];
        return acc[23:0];
    endfunction : expect_out

    task automatic final_report;
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        rd_cmp(`CFF_A_CTRL, `CFF_CTRL_RST);
        bus(1'b1, 6'h30, 16'hFFFF);
        rd_cmp(6'h30, '0);
        load(16'h7A5C, 1'b0);
        for (int cw = 0; cw < 4; cw++) begin
            cfg(cw, 0, 1'b0);
            run(16'h0100, 1'b1, expect_out(cw, 0, 16'h7A5C, 16'h0100, 1));
        end
        load(16'h4000, 1'b0);
        for (int sc = 0; sc < 4; sc++) begin
            cfg(3, sc, 1'b0);
            run(16'hA000, 1'b1, expect_out(3, sc, 16'h4000, 16'hA000, 1));
        end
        cfg(3, 2, 1'b0);
        run(16'h6000, 1'b1, 24'h00_3000);
        // Recirculate that result through the next factor's coefficient
        bus(1'b1, 6'h00, 16'h2000);
        run(16'h3000, 1'b1, 24'h00_0C00);
        // Second sample inside the busy window is dropped and flagged
        bus(1'b1, `CFF_A_DIR, 16'h4000);
        bus(1'b1, `CFF_A_DIR, 16'h4000);
        rd_cmp(`CFF_A_STAT, 24'h00_0005);
        bus(1'b1, `CFF_A_STAT, '0);
        rd_cmp(`CFF_A_STAT, 24'h00_0001);
        repeat (40) @(negedge mclk);
        rd_cmp(`CFF_A_DOL, 24'h00_1000);
        // All taps at full scale: the sum needs every one of its bits
        load(16'h8000, 1'b1);
        cfg(3, 3, 1'b0);
        for (int k = 0; k < 32; k++) begin
            run(16'h7FFF, k == 31, expect_out(3, 3, 16'h8000, 16'h7FFF, 32));
        end
        // Dedicated ports with the receiver stalled for two results
        load(16'h4000, 1'b0);
        cfg(3, 2, 1'b1);
        res_ready = 1'b0;
        feed(16'h4000);
        feed(16'hC000);
        res_ready = 1'b1;
        take(24'h00_2000);
        take(24'hFF_E000);
        final_report();
    end

    // Watchdog well beyond the expected few thousand cycles
    initial begin
        #2_000_000;
        fails++;
        final_report();
    end
endmodule : cascadable_fir_filter_datapath_bench
